// file: include/apd_pkg.sv
// shared constants, types and decode functions of the phase delay block
package apd_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CH = 4;
  localparam int BANK_W = 12;
  localparam int WORD_W = 24;
  localparam int TRIM_W = 8;
  localparam int PH_W = 12;
  localparam int COMP_W = 4;
  localparam int OSR_SEL_W = 3;
  localparam int PRE_SEL_W = 2;
  localparam int PRE_CNT_W = 3;

  // ==========================================================
  // field positions and register indices
  localparam int BANK_A_LSB = 0;
  localparam int BANK_B_LSB = 12;
  localparam int TRIM_LSB = 0;
  localparam int SIGN_MIN_POS = 4;
  localparam logic REG_FIRST_CONFIG = 1'b0;
  localparam logic REG_PAIR_DELAY = 1'b1;

  // ==========================================================
  // values after reset
  localparam logic [WORD_W-1:0] PAIR_RST = 24'h000000;
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'h50;
  localparam logic [COMP_W-1:0] COMP_HOLD = 4'h3;
  localparam logic [COMP_W-1:0] COMP_FREE = 4'h0;

  typedef enum logic {ST_HELD, ST_RUN} apd_state_t;

  // ==========================================================
  // half the oversampling ratio: 16 at selection 0, 2048 at 7
  function automatic logic [PH_W-1:0] osr_half(
    input logic [OSR_SEL_W-1:0] sel
  );
    return 12'h010 << sel;
  endfunction : osr_half

  // one less than the oversampling ratio
  function automatic logic [PH_W-1:0] osr_mask(
    input logic [OSR_SEL_W-1:0] sel
  );
    logic [PH_W:0] w;
    w = {osr_half(sel), 1'b0};
    return w[PH_W-1:0] - 12'h001;
  endfunction : osr_mask

  // last prescaler count: divide by 1, 2, 4 or 8
  function automatic logic [PRE_CNT_W-1:0] pre_last(
    input logic [PRE_SEL_W-1:0] sel
  );
    logic [PRE_CNT_W:0] w;
    w = 4'h1 << sel;
    return w[PRE_CNT_W-1:0] - 3'h1;
  endfunction : pre_last

endpackage : apd_pkg

// file: logic/apd_chan_latch.sv
// output code holder of one converter channel
`timescale 1ns/1ns
module apd_chan_latch #(
  parameter int CODE_W = 24
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic clear,
  input wire logic fire,
  input wire logic [CODE_W-1:0] data_in,
  output logic [CODE_W-1:0] data_q
);
  import apd_pkg::*;

  logic [CODE_W-1:0] data_d;

  assign data_d = clear ? '0 : (fire ? data_in : data_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      data_q <= '0;
    end else if (clock_enable) begin
      data_q <= data_d;
    end
  end

  a_clear_zero: assert property (@(posedge clock) disable iff (reset)
    clock_enable && clear |=> data_q == '0)
    else $error("channel code not zero while held");

endmodule : apd_chan_latch

// file: logic/apd_delay_calc.sv
// scales one signed delay bank to the ratio and gives the ready phase
`timescale 1ns/1ns
module apd_delay_calc (
  input wire logic [apd_pkg::BANK_W-1:0] bank,
  input wire logic [apd_pkg::OSR_SEL_W-1:0] osr_sel,
  output logic [apd_pkg::PH_W-1:0] target
);
  import apd_pkg::*;

  logic [PH_W-1:0] mask;
  logic [PH_W-1:0] half;
  logic [PH_W-1:0] kept;
  logic [PH_W:0] sum;

  // bits above the sign position are dropped; adding half the ratio
  // modulo the ratio turns the signed offset into a phase 0..ratio-1
  assign mask = osr_mask(osr_sel);
  assign half = osr_half(osr_sel);
  assign kept = bank & mask;
  assign sum = {1'b0, kept} + {1'b0, half};
  assign target = sum[PH_W-1:0] & mask;

endmodule : apd_delay_calc

// file: logic/apd_top.sv
// pair phase delay, conversion timing and hard reset control
`timescale 1ns/1ns
// Behaviour
// - each pair keeps a fixed programmable delay; all four sample together
// - odd channels are the reference and raise ready at the same instant
// - one word holds bank 1/0 in bits 11..0, bank 3/2 in 23..12
// - bank is a signed modulator-period offset of even from odd channel
// - positive value makes even lag; negative value makes even lead
// - first ready comes half the ratio in periods after reset
// - usable delay spans minus half ratio to half ratio minus one
// - any pair word write, same value too, restarts all converters
// - sign bit moves from bit 11 at 4096 down to bit 4 at 32
// - delay steps in whole modulator clock periods
// - delay time follows prescaler and master clock rate
// - while hard reset is low, converters held with zero output code
// - hard reset clears modulators and forces comparator pattern 0011
// - hard reset clears filters, their buffers and every register
// - serial writes ignored during hard reset, independent of serial port
// - serial data and ready outputs float during hard reset
// - after reset, ready pulses run with default register contents
// - first config register bits 7..0 hold tempco trim, reset 0x50
// - in link mode every active channel signals ready at the most lagging one's instant
module apd_top #(
  parameter int CODE_W = 24
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic reset_n_pin,
  input wire logic [apd_pkg::PRE_SEL_W-1:0] prescale_sel,
  input wire logic [apd_pkg::OSR_SEL_W-1:0] osr_sel,
  input wire logic ready_link_select,
  input wire logic [apd_pkg::NUM_CH-1:0] chan_active,
  input wire logic reg_write,
  input wire logic reg_addr,
  input wire logic [apd_pkg::WORD_W-1:0] reg_wdata,
  input wire logic [apd_pkg::NUM_CH*CODE_W-1:0] filter_data,
  output logic [apd_pkg::WORD_W-1:0] pair_delay_word,
  output logic [apd_pkg::TRIM_W-1:0] reference_tempco_trim,
  output logic [apd_pkg::NUM_CH*CODE_W-1:0] channel_data,
  output logic [apd_pkg::NUM_CH-1:0] channel_fire,
  output logic modulator_clock,
  output logic converter_restart,
  output logic modulator_hold,
  output logic filter_clear,
  output logic [apd_pkg::COMP_W-1:0] comparator_force,
  output logic data_ready_n_pin,
  output logic data_ready_n_oe,
  output logic serial_out_oe
);
  import apd_pkg::*;

  // ==========================================================
  // elaboration checks
  if (CODE_W < 1) begin : g_bad_code
    $error("code width must be at least one");
  end
  if (BANK_W != PH_W) begin : g_bad_bank
    $error("bank width must equal phase counter width");
  end

  // ==========================================================
  // hard reset pin synchroniser and hold state
  logic pin_meta_q;
  logic pin_sync_q;
  logic hard_req;
  apd_state_t state_q;
  apd_state_t state_d;
  logic in_hold;
  logic leave_hold;

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else if (clock_enable) begin
      pin_meta_q <= reset_n_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // the pin acts on its own, whatever the serial side does
  assign hard_req = !pin_sync_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HELD: if (!hard_req) state_d = ST_RUN;
      ST_RUN: if (hard_req) state_d = ST_HELD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_HELD;
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  assign in_hold = (state_q == ST_HELD);
  assign leave_hold = in_hold && (state_d == ST_RUN);

  // ==========================================================
  // registers
  logic [WORD_W-1:0] pair_q;
  logic [WORD_W-1:0] pair_d;
  logic [TRIM_W-1:0] trim_q;
  logic [TRIM_W-1:0] trim_d;
  logic write_ok;
  logic write_pair;
  logic write_cfg;
  logic restart;

  // a pending pin request already blocks writes one cycle early
  assign write_ok = reg_write && !in_hold && !hard_req;
  assign write_pair = write_ok && (reg_addr == REG_PAIR_DELAY);
  assign write_cfg = write_ok && (reg_addr == REG_FIRST_CONFIG);
  assign pair_d = in_hold ? PAIR_RST
                : (write_pair ? reg_wdata : pair_q);
  assign trim_d = in_hold ? TRIM_RST
                : (write_cfg ? reg_wdata[TRIM_LSB +: TRIM_W]
                : trim_q);
  // rewriting the same value still restarts every converter
  assign restart = write_pair || leave_hold;

  always_ff @(posedge clock) begin
    if (reset) begin
      pair_q <= PAIR_RST;
      trim_q <= TRIM_RST;
    end else if (clock_enable) begin
      pair_q <= pair_d;
      trim_q <= trim_d;
    end
  end

  assign pair_delay_word = pair_q;
  assign reference_tempco_trim = trim_q;

  // ==========================================================
  // modulator clock from prescaler
  logic [PRE_CNT_W-1:0] pre_q;
  logic [PRE_CNT_W-1:0] pre_d;
  logic tick;
  logic running;

  assign running = !in_hold && !restart;
  assign tick = clock_enable && running
              && (pre_q == pre_last(prescale_sel));
  assign pre_d = (!running || tick) ? '0 : pre_q + 3'h1;

  always_ff @(posedge clock) begin
    if (reset) begin
      pre_q <= '0;
    end else if (clock_enable) begin
      pre_q <= pre_d;
    end
  end

  // ==========================================================
  // phase counter, one step per modulator period
  logic [PH_W-1:0] ph_q;
  logic [PH_W-1:0] ph_d;
  logic [PH_W:0] ph_inc;
  logic [PH_W-1:0] ph_next;
  logic [PH_W-1:0] half;
  logic [PH_W-1:0] mask;

  assign half = osr_half(osr_sel);
  assign mask = osr_mask(osr_sel);
  assign ph_inc = {1'b0, ph_q} + 13'h0001;
  assign ph_next = ph_inc[PH_W-1:0] & mask;
  assign ph_d = !running ? '0 : (tick ? ph_next : ph_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      ph_q <= '0;
    end else if (clock_enable) begin
      ph_q <= ph_d;
    end
  end

  // ==========================================================
  // ready phase of each channel
  logic [PH_W-1:0] tgt [NUM_CH];
  logic [PH_W-1:0] lag_tgt;
  logic [PH_W-1:0] lag_key;
  logic lag_any;
  logic [NUM_CH-1:0] own_fire;
  logic [NUM_CH-1:0] link_vec;
  logic [NUM_CH-1:0] fire_vec;
  logic link_fire;

  for (genvar p = 0; p < NUM_CH / 2; p++) begin : g_pair
    apd_delay_calc u_calc (
      .bank(pair_q[p*BANK_W +: BANK_W]),
      .osr_sel(osr_sel),
      .target(tgt[2*p])
    );
    // odd channels sit at half the ratio from restart
    assign tgt[2*p+1] = half;
  end

  // a target of zero fires after a full ratio, so it lags the most:
  // channels are ordered by target minus one, modulo the ratio
  always_comb begin
    lag_tgt = '0;
    lag_key = '0;
    lag_any = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (chan_active[i]
          && (!lag_any || (((tgt[i] - 12'h001) & mask) > lag_key))) begin
        lag_tgt = tgt[i];
        lag_key = (tgt[i] - 12'h001) & mask;
        lag_any = 1'b1;
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_hit
    assign own_fire[c] = tick && chan_active[c]
                       && (ph_next == tgt[c]);
  end

  assign link_fire = tick && (ph_next == lag_tgt);
  assign link_vec = {NUM_CH{link_fire}} & chan_active;
  assign fire_vec = ready_link_select ? link_vec : own_fire;

  // ==========================================================
  // channel output codes
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    apd_chan_latch #(
      .CODE_W(CODE_W)
    ) u_latch (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .clear(in_hold),
      .fire(fire_vec[c]),
      .data_in(filter_data[c*CODE_W +: CODE_W]),
      .data_q(channel_data[c*CODE_W +: CODE_W])
    );
  end

  // ==========================================================
  // pins and converter controls
  logic ready_n_q;
  logic oe_q;
  logic [NUM_CH-1:0] fire_q;
  logic tick_q;
  logic restart_q;
  logic clear_q;
  logic [COMP_W-1:0] comp_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      ready_n_q <= 1'b1;
      oe_q <= 1'b0;
      fire_q <= '0;
      tick_q <= 1'b0;
      restart_q <= 1'b0;
      clear_q <= 1'b1;
      comp_q <= COMP_HOLD;
    end else if (clock_enable) begin
      ready_n_q <= !(|fire_vec);
      oe_q <= !hard_req && !in_hold;
      fire_q <= fire_vec;
      tick_q <= tick;
      restart_q <= restart;
      clear_q <= hard_req || restart;
      comp_q <= hard_req ? COMP_HOLD : COMP_FREE;
    end
  end

  assign data_ready_n_pin = ready_n_q;
  assign data_ready_n_oe = oe_q;
  assign serial_out_oe = oe_q;
  assign channel_fire = fire_q;
  assign modulator_clock = tick_q;
  assign converter_restart = restart_q;
  assign modulator_hold = in_hold;
  assign filter_clear = clear_q;
  assign comparator_force = comp_q;

  // ==========================================================
  // checks
  sequence s_pair_written;
    clock_enable && write_pair;
  endsequence

  sequence s_counter_restarted;
    ph_q == '0 && converter_restart && filter_clear;
  endsequence

  a_write_restart: assert property (@(posedge clock) disable iff (reset)
    s_pair_written |=> s_counter_restarted)
    else $error("pair word write did not restart counting");

  a_odd_pair_sync: assert property (@(posedge clock) disable iff (reset)
    fire_vec[1] && chan_active[3] |-> fire_vec[3])
    else $error("odd channels ready apart");

  a_odd_ref_pos: assert property (@(posedge clock) disable iff (reset)
    !ready_link_select && fire_vec[1] |-> ph_next == half)
    else $error("odd channel ready off half ratio");

  a_even_offset: assert property (@(posedge clock) disable iff (reset)
    !ready_link_select && fire_vec[0]
    |-> ph_next == ((half + pair_q[BANK_A_LSB +: BANK_W]) & mask))
    else $error("even channel ready off its bank");

  a_bank_scaling: assert property (@(posedge clock) disable iff (reset)
    ((tgt[2] - half) & mask) == (pair_q[BANK_B_LSB +: BANK_W] & mask)
    && tgt[2] <= mask)
    else $error("bank not scaled to ratio");

  a_hold_outputs: assert property (@(posedge clock) disable iff (reset)
    clock_enable && hard_req |=> !data_ready_n_oe && !serial_out_oe
    && comparator_force == COMP_HOLD && filter_clear)
    else $error("outputs not released in hard reset");

  a_hold_writes: assert property (@(posedge clock) disable iff (reset)
    clock_enable && in_hold |=> pair_q == PAIR_RST
    && trim_q == TRIM_RST)
    else $error("register changed in hard reset");

  a_trim_default: assert property (@(posedge clock)
    reset |=> reference_tempco_trim == TRIM_RST)
    else $error("trim not at default after reset");

  a_link_lag: assert property (@(posedge clock) disable iff (reset)
    ready_link_select && (|fire_vec)
    |-> fire_vec == chan_active && ph_next == lag_tgt)
    else $error("linked ready not on most lagging channel");

  a_ready_pulse: assert property (@(posedge clock) disable iff (reset)
    clock_enable && (|fire_vec) |=> !data_ready_n_pin
    ##1 (data_ready_n_pin || !$stable(fire_q) || !clock_enable))
    else $error("ready pulse missing or stretched");

endmodule : apd_top

// file: verification/apd_host_model.sv
// host side model: settles after restart, counts ready pulses, checks defaults
`timescale 1ns/1ns
module apd_host_model #(
  parameter int SETTLE_CYC = 40
) (
  input wire logic clock,
  input wire logic restart,
  input wire logic ready_n,
  input wire logic [apd_pkg::WORD_W-1:0] pair_word,
  input wire logic [apd_pkg::TRIM_W-1:0] trim,
  output logic [15:0] accepted,
  output logic power_up_ok
);
  import apd_pkg::*;
  int since;
  logic first_q;
  logic ready_q;

  // ==========================================================
  // pulse intake
  initial begin
    since = 0;
    accepted = 16'h0000;
    power_up_ok = 1'b0;
    first_q = 1'b1;
    ready_q = 1'b1;
  end

  always @(posedge clock) begin
    ready_q <= ready_n;
    if (restart === 1'b1) begin
      since <= 0;
      if (first_q) begin
        power_up_ok <= (pair_word === PAIR_RST) && (trim === TRIM_RST);
        first_q <= 1'b0;
      end
    end else begin
      since <= since + 1;
    end
    // early pulses are dropped while the filters settle
    if (ready_q && !ready_n && since >= SETTLE_CYC) begin
      accepted <= accepted + 16'h0001;
    end
  end
endmodule : apd_host_model

// file: verification/apd_top_tb_top.sv
// self-checking bench of the pair phase delay block
`timescale 1ns/1ns
module apd_top_tb_top;
  import apd_pkg::*;
  localparam int NT = 9;
  logic clock, reset, clock_enable, reset_n_pin, ready_link_select;
  logic [PRE_SEL_W-1:0] prescale_sel;
  logic [OSR_SEL_W-1:0] osr_sel;
  logic [NUM_CH-1:0] chan_active, channel_fire;
  logic reg_write, reg_addr;
  logic [WORD_W-1:0] reg_wdata, pair_delay_word;
  logic [TRIM_W-1:0] reference_tempco_trim;
  logic [NUM_CH*24-1:0] filter_data, channel_data;
  logic modulator_clock, converter_restart, modulator_hold, filter_clear;
  logic [COMP_W-1:0] comparator_force;
  logic data_ready_n_pin, data_ready_n_oe, serial_out_oe, ready_wire;
  logic host_ok;
  logic [15:0] host_count;
  int n_mismatch, checks, tr, dv, mx, mn, nt;
  int t[NUM_CH];
  int e[NUM_CH];
  int osr_t[NT] = '{0, 0, 1, 3, 3, 0, 0, 0, 0};
  int pre_t[NT] = '{0, 0, 0, 0, 0, 2, 0, 0, 0};
  logic lnk_t[NT] = '{0, 0, 0, 0, 0, 0, 1, 1, 1};
  logic [3:0] act_t[NT] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hE,
    4'hF};
  logic [23:0] wd_t[NT] = '{24'hFF000F, 24'hFFB7E3, 24'h01F021, 24'h07F080,
    24'h07F080, 24'h000003, 24'hFFD005, 24'hFFD005, 24'h000010};

  apd_top u_dut (.clock, .reset, .clock_enable, .reset_n_pin, .prescale_sel,
    .osr_sel, .ready_link_select, .chan_active, .reg_write, .reg_addr,
    .reg_wdata, .filter_data, .pair_delay_word, .reference_tempco_trim,
    .channel_data, .channel_fire, .modulator_clock, .converter_restart,
    .modulator_hold, .filter_clear, .comparator_force, .data_ready_n_pin,
    .data_ready_n_oe, .serial_out_oe);

  // the host pulls the released ready line up
  assign ready_wire = data_ready_n_oe ? data_ready_n_pin : 1'b1;

  apd_host_model u_host (.clock, .restart(converter_restart),
    .ready_n(ready_wire), .pair_word(pair_delay_word),
    .trim(reference_tempco_trim), .accepted(host_count),
    .power_up_ok(host_ok));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic a, input logic [23:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // first fire and ready cycle of each channel, counted from the restart
  task automatic frame(input int lim);
    int base;
    base = -1;
    tr = -1;
    nt = 0;
    foreach (t[c]) t[c] = -1;
    for (int k = 0; k < lim; k++) begin
      #1;
      if (base < 0 && converter_restart === 1'b1) base = k;
      if (base >= 0) begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (channel_fire[c] === 1'b1 && t[c] < 0) t[c] = k - base;
        end
        // modulator periods up to and including the first ready cycle
        if (modulator_clock === 1'b1 && tr < 0) nt++;
        if (ready_wire === 1'b0 && tr < 0) tr = k - base;
      end
      @(posedge clock);
    end
    if (base < 0) begin
      n_mismatch++;
      final_report;
    end
  endtask : frame

  function automatic int tgt(input int oversampling_ratio, input logic [11:0] b);
    int half, s, v;
    half = 16 << oversampling_ratio;
    s = 4 + oversampling_ratio;
    v = int'(b) & ((2 << s) - 1);
    if (v >= (1 << s)) v -= (2 << s);
    v = (half + v) % (2 * half);
    return (v == 0) ? 2 * half : v;
  endfunction : tgt

  initial begin
    repeat (50000) @(posedge clock);
    n_mismatch++;
    final_report;
  end

  // ==========================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    reset = 1'b1;
    clock_enable = 1'b1;
    reset_n_pin = 1'b0;
    prescale_sel = '0;
    osr_sel = '0;
    ready_link_select = 1'b0;
    chan_active = 4'hF;
    reg_write = 1'b0;
    reg_addr = 1'b0;
    reg_wdata = '0;
    filter_data = {24'hC00003, 24'hB00002, 24'hA00001, 24'h900000};
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    wr(1'b1, 24'h123456);
    #1;
    check(pair_delay_word, PAIR_RST);
    check(reference_tempco_trim, TRIM_RST);
    check({data_ready_n_oe, serial_out_oe, modulator_hold}, 3'h1);
    check(comparator_force, COMP_HOLD);
    check(channel_data, '0);
    @(posedge clock);
    reset_n_pin <= 1'b1;
    frame(60);
    check(tr, 16);
    check(nt, 16);
    check(host_ok, 1'b1);
    check(host_count, 16'h0001);
    check({data_ready_n_oe, serial_out_oe}, 2'h3);
    check(comparator_force, COMP_FREE);
    wr(1'b0, 24'hABC42);
    #1;
    check(reference_tempco_trim, 8'h42);
    for (int i = 0; i < NT; i++) begin
      @(posedge clock);
      osr_sel <= OSR_SEL_W'(osr_t[i]);
      prescale_sel <= PRE_SEL_W'(pre_t[i]);
      ready_link_select <= lnk_t[i];
      chan_active <= act_t[i];
      wr(1'b1, wd_t[i]);
      dv = 1 << pre_t[i];
      frame((64 << osr_t[i]) * dv + 8);
      mx = -1;
      mn = 1 << 20;
      for (int c = 0; c < NUM_CH; c++) begin
        e[c] = tgt(osr_t[i], c[0] ? 12'h000 : wd_t[i][c*6 +: 12]) * dv;
        if (!act_t[i][c]) e[c] = -1;
        if (e[c] > mx) mx = e[c];
        if (e[c] >= 0 && e[c] < mn) mn = e[c];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        check(t[c], (lnk_t[i] && e[c] >= 0) ? mx : e[c]);
      end
      check(tr, lnk_t[i] ? mx : mn);
      check(nt, (lnk_t[i] ? mx : mn) / dv);
      check(t[1], t[3]);
      if (i == 0) check(channel_data, filter_data);
    end
    @(posedge clock);
    reset_n_pin <= 1'b0;
    repeat (4) @(posedge clock);
    wr(1'b1, 24'h000111);
    #1;
    check(pair_delay_word, PAIR_RST);
    check(reference_tempco_trim, TRIM_RST);
    check(channel_data, '0);
    check({filter_clear, modulator_hold}, 2'h3);
    check(comparator_force, COMP_HOLD);
    check({data_ready_n_oe, serial_out_oe}, 2'h0);
    final_report;
  end
endmodule : apd_top_tb_top
